// *** include/uvlo_defs.vh ***
// Purpose: Constants for the low-line lockout qualifier and quadrant control
// Assumes: 200 MHz mclk; ramp and clock events arrive as asynchronous levels
// Notes:   Functional notes follow
// Functional notes
// - A master clock period whose clock pulse arrives before the ramp reached 90% is a low-line cycle, else good.
// - Soft-start stays low until the input supply has been qualified.
// - A three-bit count of seven good cycles raises power-good, starts soft-start and forces both drives off then.
// - After soft-start begins, seven low-line counts are needed before undervoltage is declared.
// - PWM start-up is inhibited while the ramp fails to complete within the clock period.
// - Each ramp cycle is timed from the master clock; ramp and oscillator stay separate.
// - The source/sink variant always runs two-quadrant, driving both switches synchronously.
// - The source-only variant never sinks; non-synchronous when discontinuous, synchronous when continuous.
// - The pre-bias variant runs single-quadrant in start-up and goes two-quadrant only after regulation.
// - A falling edge on the sync input replaces the internal oscillator as master clock; low means free run.
`ifndef UVLO_DEFS_VH
`define UVLO_DEFS_VH
// ---------------------------------------------------------------
// Counter and variant codes
// ---------------------------------------------------------------
`define QUAL_W        3
`define QUAL_MAX      3'h7
`define QUAL_ZERO     3'h0
`define VAR_SOURCE    2'h0
`define VAR_SRC_SINK  2'h1
`define VAR_PREBIAS   2'h2
// ---------------------------------------------------------------
// Sync timing
// ---------------------------------------------------------------
`define SYNC_IDLE_NS  2000
`define CLK_PERIOD_NS 5
`define SYNC_IDLE_CYC ((`SYNC_IDLE_NS) / (`CLK_PERIOD_NS))
`endif

// *** rtl/edge_sync.v ***
// Purpose: Three-stage synchroniser with agreement-based edge detection
// Assumes: Input is asynchronous to mclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module edge_sync (
  input  wire mclk,
  input  wire nrst,
  input  wire din,
  output reg  level,
  output reg  rise,
  output reg  fall
);
  reg s1;
  reg s2;
  reg s3;

  // ---------------------------------------------------------------
  // Synchroniser chain and qualified level
  // ---------------------------------------------------------------
  // Level changes once stages two and three agree
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      s1    <= din;
      s2    <= s1;
      s3    <= s2;
      rise  <= 1'b0;
      fall  <= 1'b0;
      if (s2 == s3 && s3 != level) begin
        level <= s3;
        rise  <= s3;
        fall  <= ~s3;
      end
    end
  end
endmodule

// *** rtl/uvlo_qualifier.v ***
// Purpose: Low-line lockout qualifier, soft-start gating and quadrant select
// Assumes: Ramp-90% and oscillator pulse come from analog comparators
// Notes:   Variant picked by a strap input sampled after reset release
`timescale 1ns/10ps
`include "uvlo_defs.vh"
module uvlo_qualifier #(
  parameter SYNC_IDLE = `SYNC_IDLE_CYC
) (
  input  wire       mclk,
  input  wire       nrst,
  input  wire       osc_pulse,
  input  wire       sync_in,
  input  wire       ramp_at_90,
  input  wire       shutdown,
  input  wire       in_regulation,
  input  wire       inductor_cont,
  input  wire [1:0] variant_strap,
  output reg        master_clk_evt,
  output reg        ramp_start,
  output reg        power_good,
  output reg        soft_start_en,
  output reg        pwm_inhibit,
  output reg        drives_off,
  output reg        uv_declared,
  output reg        sync_mode,
  output reg        allow_sink,
  output reg        sync_rect_en,
  output reg  [2:0] qual_count
);
  localparam ST_LOCK = 3'b001;
  localparam ST_SS   = 3'b010;
  localparam ST_RUN  = 3'b100;

  wire       osc_rise;
  wire       sync_fall;
  wire       sync_lvl;
  wire       ramp_rise;
  reg  [2:0] state;
  reg  [2:0] next_state;
  reg  [2:0] next_count;
  reg        ramp_done;
  reg  [1:0] variant;
  reg        strap_taken;
  reg  [12:0] idle_cnt;
  reg        tick;
  reg        good;

  // Saturating step of the qualification count
  function [2:0] sat_step;
    input [2:0] v;
    input       up;
    begin
      if (up)
        sat_step = (v == `QUAL_MAX) ? v : v + 3'h1;
      else
        sat_step = (v == `QUAL_ZERO) ? v : v - 3'h1;
    end
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  edge_sync u_osc (
    .mclk  (mclk),
    .nrst  (nrst),
    .din   (osc_pulse),
    .level (),
    .rise  (osc_rise),
    .fall  ()
  );

  edge_sync u_sync (
    .mclk  (mclk),
    .nrst  (nrst),
    .din   (sync_in),
    .level (sync_lvl),
    .rise  (),
    .fall  (sync_fall)
  );

  edge_sync u_ramp (
    .mclk  (mclk),
    .nrst  (nrst),
    .din   (ramp_at_90),
    .level (),
    .rise  (ramp_rise),
    .fall  ()
  );

  // ---------------------------------------------------------------
  // Master clock selection
  // ---------------------------------------------------------------
  // Sync mode holds while edges keep coming; idle low falls back
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_mode <= 1'b0;
      idle_cnt  <= 13'h0;
    end else if (sync_fall) begin
      sync_mode <= 1'b1;
      idle_cnt  <= 13'h0;
    end else if (sync_lvl) begin
      idle_cnt  <= 13'h0;
    end else if (idle_cnt >= SYNC_IDLE[12:0]) begin
      sync_mode <= 1'b0;
    end else begin
      idle_cnt  <= idle_cnt + 13'h1;
    end
  end

  // Tick from sync falling edge or oscillator
  always @* begin
    tick = sync_mode ? sync_fall : osc_rise;
  end

  // ---------------------------------------------------------------
  // Ramp timing per master period
  // ---------------------------------------------------------------
  // Ramp restarts each tick; remembers the 90% crossing itself, since the
  // comparator level of the old ramp can outlast the tick and fake a good period
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ramp_done      <= 1'b0;
      ramp_start     <= 1'b0;
      master_clk_evt <= 1'b0;
    end else begin
      master_clk_evt <= tick;
      ramp_start     <= tick;
      if (tick)
        ramp_done <= 1'b0;
      else if (ramp_rise)
        ramp_done <= 1'b1;
    end
  end

  // Cycle good when ramp reached 90% before the tick
  always @* begin
    good = ramp_done | ramp_rise;
  end

  // ---------------------------------------------------------------
  // Qualification state machine
  // ---------------------------------------------------------------
  always @* begin
    next_state = state;
    next_count = qual_count;
    case (state)
      ST_LOCK: begin
        if (tick) begin
          next_count = sat_step(qual_count, good);
          if (good && qual_count == 3'h6) begin
            next_state = ST_SS;
            next_count = `QUAL_ZERO;
          end
        end
      end
      ST_SS, ST_RUN: begin
        if (tick) begin
          next_count = sat_step(qual_count, ~good);
          if (!good && qual_count == 3'h6) begin
            next_state = ST_LOCK;
            next_count = `QUAL_ZERO;
          end
        end
        if (state == ST_SS && in_regulation && next_state == ST_SS)
          next_state = ST_RUN;
      end
      default: begin
        next_state = ST_LOCK;
        next_count = `QUAL_ZERO;
      end
    endcase
    if (shutdown) begin
      next_state = ST_LOCK;
      next_count = `QUAL_ZERO;
    end
  end

  // State, count and strap capture
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state       <= ST_LOCK;
      qual_count  <= `QUAL_ZERO;
      variant     <= `VAR_SOURCE;
      strap_taken <= 1'b0;
    end else begin
      state      <= next_state;
      qual_count <= next_count;
      if (!strap_taken) begin
        variant     <= variant_strap;
        strap_taken <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Status and drive control outputs
  // ---------------------------------------------------------------
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      power_good    <= 1'b0;
      soft_start_en <= 1'b0;
      pwm_inhibit   <= 1'b1;
      drives_off    <= 1'b1;
      uv_declared   <= 1'b0;
      allow_sink    <= 1'b0;
      sync_rect_en  <= 1'b0;
    end else begin
      power_good    <= next_state != ST_LOCK;
      soft_start_en <= next_state != ST_LOCK;
      // Inhibit while unqualified or this period's ramp failed
      pwm_inhibit   <= (next_state == ST_LOCK) | (tick & ~good);
      drives_off    <= (next_state == ST_LOCK) | (state == ST_LOCK);
      uv_declared   <= (state != ST_LOCK) & (next_state == ST_LOCK) & ~shutdown;
      case (variant)
        `VAR_SRC_SINK: begin
          allow_sink   <= 1'b1;
          sync_rect_en <= 1'b1;
        end
        `VAR_PREBIAS: begin
          allow_sink   <= next_state == ST_RUN;
          sync_rect_en <= next_state == ST_RUN;
        end
        default: begin
          allow_sink   <= 1'b0;
          sync_rect_en <= inductor_cont;
        end
      endcase
    end
  end
endmodule

// *** verif/ramp_osc_model.sv ***
// Purpose: Oscillator and ramp comparator stand-in
// Assumes: Period of 24 mclk, ramp reaches 90% at count 12
// Notes:   fast low means the ramp never completes in time
`timescale 1ns/10ps
module ramp_osc_model (
  input  wire  mclk,
  input  wire  nrst,
  input  wire  fast,
  output logic osc_pulse,
  output logic ramp_at_90
);
  logic [4:0] cnt;
  logic       done;
  // Period counter, ramp outcome fixed mid-period
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt  <= 5'h00;
      done <= 1'b0;
    end else begin
      cnt <= (cnt == 5'h17) ? 5'h00 : cnt + 5'h01;
      if (cnt == 5'h0b) done <= fast;
    end
  end
  // Clock pulse opens each period; flag held just past it
  assign osc_pulse  = (cnt < 5'h04);
  assign ramp_at_90 = done && (cnt > 5'h0b || cnt < 5'h03);
endmodule

// *** verif/uvlo_qualifier_asserts.sv ***
// Purpose: Port-level checks of the lockout qualifier
// Assumes: Single mclk domain, nrst active low
// Notes:   Attached by bind below
`timescale 1ns/10ps
module uvlo_qualifier_asserts (
  input wire       mclk,
  input wire       nrst,
  input wire       master_clk_evt,
  input wire       power_good,
  input wire       soft_start_en,
  input wire       pwm_inhibit,
  input wire       drives_off,
  input wire       uv_declared,
  input wire       allow_sink,
  input wire       sync_rect_en,
  input wire [1:0] variant_strap
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  a_softstart_gate: assert property (!power_good |-> !soft_start_en)
    else $error("soft start without power good");
  a_qualify_drives: assert property ($rose(power_good) |-> drives_off)
    else $error("drives not off at qualification");
  a_uv_drops_pg: assert property (uv_declared |-> ##[0:1] !power_good)
    else $error("power good kept after undervoltage");
  a_uv_single: assert property (uv_declared |=> !uv_declared)
    else $error("undervoltage pulse too long");
  a_inhibit_locked: assert property (!power_good |-> pwm_inhibit)
    else $error("start-up not inhibited while locked");
  a_tick_single: assert property (master_clk_evt |=> !master_clk_evt)
    else $error("master tick pulse too long");
  a_sink_sync: assert property (allow_sink |-> sync_rect_en)
    else $error("sinking without synchronous drive");
  a_source_nosink: assert property (variant_strap == 2'h0 |-> !allow_sink)
    else $error("source-only variant sinks");
endmodule
bind uvlo_qualifier uvlo_qualifier_asserts chk (.mclk, .nrst, .master_clk_evt, .power_good,
  .soft_start_en, .pwm_inhibit, .drives_off, .uv_declared, .allow_sink, .sync_rect_en,
  .variant_strap);

// *** verif/uvlo_qualifier_test.sv ***
// Purpose: Self-checking bench for the lockout qualifier
// Assumes: Ramp model period of 24 mclk
// Notes:   Counter model steps once per master tick
`timescale 1ns/10ps
module uvlo_qualifier_test;
  logic       mclk = 1'b0;
  logic       nrst = 1'b0;
  logic       fast = 1'b0;
  logic       in_regulation = 1'b0;
  logic       inductor_cont = 1'b0;
  logic [1:0] variant_strap = 2'h0;
  logic       uv_seen = 1'b0;
  logic       shutdown = 1'b0;
  logic       sync_in = 1'b0;
  wire        ramp_start;
  wire        soft_start_en;
  wire        pwm_inhibit;
  wire        drives_off;
  wire        sync_mode;
  wire        sync_rect_en;
  int         var_sel;
  int         evts;
  wire        osc_pulse;
  wire        ramp_at_90;
  wire        master_clk_evt;
  wire        power_good;
  wire        uv_declared;
  wire        allow_sink;
  wire  [2:0] qual_count;
  int         mismatches = 0;
  int         checked = 0;
  int         cycles = 0;
  int         cnt;
  int         pg;
  int         pend;
  int         seed;
  ramp_osc_model ramp (.mclk, .nrst, .fast, .osc_pulse, .ramp_at_90);
  uvlo_qualifier #(.SYNC_IDLE(20)) dut (.mclk, .nrst, .osc_pulse, .sync_in,
    .ramp_at_90, .shutdown, .in_regulation, .inductor_cont, .variant_strap,
    .master_clk_evt, .ramp_start, .power_good, .soft_start_en, .pwm_inhibit,
    .drives_off, .uv_declared, .sync_mode, .allow_sink, .sync_rect_en, .qual_count);
  task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One master tick: apply the period outcome, draw the next one
  task automatic tick(input int chance);
    int i;
    int uv;
    int nxt;
    int sink;
    int sr;
    i = 0;
    do begin
      @(negedge mclk);
      i++;
    end while (master_clk_evt !== 1'b1 && i < 40);
    check("master_clk_evt", 3'h1, {2'h0, master_clk_evt});
    check("ramp_start", 3'h1, {2'h0, ramp_start});
    nxt = ($urandom % 100) < chance;
    @(posedge mclk);
    fast <= nxt[0];
    inductor_cont <= $urandom;
    uv = 0;
    cnt = (pend != pg) ? cnt + 1 : (cnt > 0 ? cnt - 1 : 0);
    if (cnt == 7) begin
      uv = pg;
      pg = !pg;
      cnt = 0;
    end
    pend = nxt;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    sink = (var_sel == 1) || (var_sel == 2 && pg != 0 && in_regulation);
    sr = (var_sel == 0 || var_sel == 3) ? inductor_cont : sink;
    check("qual_count", cnt[2:0], qual_count);
    check("power_good", pg[2:0], {2'h0, power_good});
    check("soft_start_en", pg[2:0], {2'h0, soft_start_en});
    check("pwm_inhibit", {2'h0, pg == 0}, {2'h0, pwm_inhibit});
    check("drives_off", {2'h0, pg == 0}, {2'h0, drives_off});
    check("uv_declared", uv[2:0], {2'h0, uv_seen});
    check("allow_sink", sink[2:0], {2'h0, allow_sink});
    check("sync_rect_en", sr[2:0], {2'h0, sync_rect_en});
    check("sync_mode", 3'h0, {2'h0, sync_mode});
    uv_seen = 1'b0;
  endtask
  // External clock: each falling edge after the first is a tick, osc ignored, idle low frees
  task automatic sync_run();
    evts = 0;
    for (int k = 0; k < 72; k++) begin
      @(posedge mclk);
      sync_in <= (k % 12) < 6;
      @(negedge mclk);
      if (k >= 12 && master_clk_evt === 1'b1)
        evts++;
    end
    check("sync_mode", 3'h1, {2'h0, sync_mode});
    check("sync_ticks", 3'h5, (evts > 7) ? 3'h7 : evts[2:0]);
    repeat (30) @(posedge mclk);
    @(negedge mclk);
    check("sync_mode", 3'h0, {2'h0, sync_mode});
  endtask
  // Shutdown while qualified: lock, count cleared, no undervoltage pulse
  task automatic shut_down();
    @(posedge mclk);
    shutdown <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    check("qual_count", 3'h0, qual_count);
    check("power_good", 3'h0, {2'h0, power_good});
    check("soft_start_en", 3'h0, {2'h0, soft_start_en});
    check("uv_declared", 3'h0, {2'h0, uv_seen});
    @(posedge mclk);
    shutdown <= 1'b0;
    cnt = 0;
    pg = 0;
  endtask
  always #2.5 mclk = ~mclk;
  // Cycle limit and capture of the one-cycle undervoltage pulse
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (uv_declared === 1'b1) uv_seen <= 1'b1;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // Each variant: qualify, regulate, drop out, then random line
  initial begin
    seed = $urandom(38);
    for (int v = 0; v < 4; v++) begin
      @(posedge mclk);
      nrst <= 1'b0;
      variant_strap <= v[1:0];
      in_regulation <= 1'b0;
      fast <= 1'b0;
      var_sel = v;
      cnt = 0;
      pg = 0;
      pend = 0;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      if (v == 0)
        sync_run();
      repeat (8) tick(100);
      check("allow_sink", {2'h0, v == 1}, {2'h0, allow_sink});
      @(posedge mclk);
      in_regulation <= 1'b1;
      repeat (2) tick(100);
      check("allow_sink", {2'h0, v == 1 || v == 2}, {2'h0, allow_sink});
      repeat (8) tick(0);
      repeat (40) tick(70);
      repeat (16) tick(100);
      shut_down();
    end
    tally_and_finish();
  end
endmodule
